// *** design/fsk_pkg.sv ***
// Package with constants and types for the FSK mode sequencer and line coder.
package fsk_pkg;
   // ---------------------------------------------------------------
   // Field widths and limits
   // ---------------------------------------------------------------
   localparam int REFDIV_W = 6;
   localparam int CLKSEL_W = 3;
   localparam int MODCUR_W = 5;
   localparam int ATTEN_W = 4;
   localparam int FILT_W = 3;
   localparam logic [REFDIV_W-1:0] REFDIV_MIN = 6'h01;
   localparam logic [CLKSEL_W-1:0] CLKSEL_TOP = 3'h7;
   localparam int PRESCALE_W = 14;
   localparam int DIVCNT_W = REFDIV_W + PRESCALE_W;
   localparam logic [DIVCNT_W-1:0] DIVCNT_ONE = 20'h00001;
   localparam logic [DIVCNT_W-1:0] DIVCNT_ZERO = 20'h00000;
   localparam logic [FILT_W-1:0] FILT_OFF = 3'h0;
   // ---------------------------------------------------------------
   // Main mode encodings
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_POWER_DOWN = 2'h0;
   localparam logic [1:0] MODE_STANDBY = 2'h1;
   localparam logic [1:0] MODE_RECEIVE = 2'h2;
   localparam logic [1:0] MODE_TRANSMIT = 2'h3;
   // ---------------------------------------------------------------
   // Line coding
   // ---------------------------------------------------------------
   localparam logic [1:0] CODE_NONE = 2'h0;
   localparam logic [1:0] CODE_MANCH = 2'h1;
   localparam logic [1:0] CODE_THREE_TO_FOUR_BIT_CODE = 2'h2;
   localparam logic [1:0] MANCH_ZERO = 2'h2;
   localparam logic [1:0] MANCH_ONE = 2'h1;
   localparam logic [3:0] W000_A = 4'hB;
   localparam logic [3:0] W000_B = 4'h4;
   localparam logic [3:0] W111_A = 4'hD;
   localparam logic [3:0] W111_B = 4'h2;
   localparam logic [3:0] W001 = 4'hC;
   localparam logic [3:0] W010 = 4'h3;
   localparam logic [3:0] W011 = 4'hA;
   localparam logic [3:0] W100 = 4'h5;
   localparam logic [3:0] W101 = 4'h9;
   localparam logic [3:0] W110 = 4'h6;
   localparam logic [4:0] PREAMBLE_BITS = 5'h18;
   localparam logic [2:0] CNT_ZERO = 3'h0;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] LEN_PASS = 3'h1;
   localparam logic [2:0] LEN_MANCH = 3'h2;
   localparam logic [2:0] LEN_WORD = 3'h4;
   localparam logic [1:0] GRP_LAST = 2'h2;
   localparam logic [2:0] PA_OFF = 3'h0;

   typedef struct packed {
      logic [REFDIV_W-1:0] ref_divider;
      logic [CLKSEL_W-1:0] modulator_clock_select;
      logic [MODCUR_W-1:0] mod_current;
      logic [ATTEN_W-1:0] mod_atten;
      logic [FILT_W-1:0] mod_filter;
   } fsk_mod_cfg_t;

   typedef enum logic [3:0] {
      ST_POWER_DOWN = 4'h1,
      ST_STANDBY = 4'h2,
      ST_RECEIVE = 4'h4,
      ST_TRANSMIT = 4'h8
   } fsk_state_t;
endpackage : fsk_pkg

// *** design/fsk_clk_div.sv ***
// Modulator clock divider: crystal divided by ref_divider times 2^(7-select).
`timescale 1ns/1ns
`default_nettype none
module fsk_clk_div
   import fsk_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic run_in,
   input wire logic [REFDIV_W-1:0] ref_divider_in,
   input wire logic [CLKSEL_W-1:0] clk_select_in,
   output logic tick_out
);
   logic [DIVCNT_W-1:0] cnt_q;
   logic [DIVCNT_W-1:0] cnt_d;
   logic [DIVCNT_W-1:0] period;
   logic tick_d;
   logic tick_q;
   logic [REFDIV_W-1:0] rdiv;

   always_comb begin
      rdiv = (ref_divider_in < REFDIV_MIN) ? REFDIV_MIN : ref_divider_in;
      period = DIVCNT_W'(rdiv) << (CLKSEL_TOP - clk_select_in);
      tick_d = 1'b0;
      cnt_d = cnt_q;
      if (!run_in) begin
         cnt_d = DIVCNT_ZERO;
      end else if (cnt_q >= period - DIVCNT_ONE) begin
         cnt_d = DIVCNT_ZERO;
         tick_d = 1'b1;
      end else begin
         cnt_d = cnt_q + DIVCNT_ONE;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         cnt_q <= DIVCNT_ZERO;
         tick_q <= 1'b0;
      end else if (ce_in) begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign tick_out = tick_q;
endmodule : fsk_clk_div
`default_nettype wire

// *** design/fsk_seq.sv ***
// Mode sequencer, modulator control and DC balanced line coder.
// Functional notes
// - Modulator clock equals crystal over ref divider times two to seven minus select.
// - Ref divider 1 to 63, select 0-7, current 0-31, attenuator 0-15.
// - Filter field zero disables filtering, seven gives most filtering.
// - Two-bit mode selects power-down, standby, receive or transmit.
// - Modulator held off while data pin floats in transmit when vco_mod_sel_in is set.
`timescale 1ns/1ns
`default_nettype none
module fsk_seq
   import fsk_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [1:0] main_mode_in,
   input wire logic [2:0] pa_level_in,
   input wire logic xtal_settled_in,
   input wire logic synth_lock_indication_in,
   input wire fsk_mod_cfg_t mod_cfg_in,
   input wire logic vco_mod_sel_in,
   input wire logic tx_data_pin_driven_in,
   input wire logic tx_data_pin_level_in,
   input wire logic [1:0] code_sel_in,
   input wire logic msg_start_in,
   input wire logic msg_bit_valid_in,
   input wire logic msg_bit_in,
   output logic msg_bit_ready_out,
   output logic line_bit_out,
   output logic line_bit_valid_out,
   output logic [3:0] state_out,
   output logic osc_on_out,
   output logic rx_on_out,
   output logic tx_on_out,
   output logic pa_on_out,
   output logic modulator_en_out,
   output logic mod_clk_tick_out,
   output logic [MODCUR_W-1:0] mod_current_out,
   output logic [ATTEN_W-1:0] mod_atten_out,
   output logic [FILT_W-1:0] mod_filter_out,
   output logic filter_en_out,
   output logic lock_out
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] drv_s_q;
   logic [1:0] lvl_s_q;
   logic [1:0] lock_s_q;
   logic [1:0] xtal_s_q;
   logic pin_driven;
   logic pin_level;
   logic lock_sync;
   logic xtal_ok;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         drv_s_q <= 2'h0;
         lvl_s_q <= 2'h0;
         lock_s_q <= 2'h0;
         xtal_s_q <= 2'h0;
      end else if (ce_in) begin
         drv_s_q <= {drv_s_q[0], tx_data_pin_driven_in};
         lvl_s_q <= {lvl_s_q[0], tx_data_pin_level_in};
         lock_s_q <= {lock_s_q[0], synth_lock_indication_in};
         xtal_s_q <= {xtal_s_q[0], xtal_settled_in};
      end
   end
   assign pin_driven = drv_s_q[1];
   assign pin_level = lvl_s_q[1];
   assign lock_sync = lock_s_q[1];
   assign xtal_ok = xtal_s_q[1];

   // ---------------------------------------------------------------
   // Mode state machine
   // ---------------------------------------------------------------
   fsk_state_t state_q;
   fsk_state_t state_d;

   function automatic fsk_state_t mode_state(input logic [1:0] m);
      unique case (m)
         MODE_POWER_DOWN: mode_state = ST_POWER_DOWN;
         MODE_STANDBY: mode_state = ST_STANDBY;
         MODE_RECEIVE: mode_state = ST_RECEIVE;
         MODE_TRANSMIT: mode_state = ST_TRANSMIT;
      endcase
   endfunction : mode_state

   always_comb begin
      state_d = mode_state(main_mode_in);
      // Radio modes from power-down stay in standby until the crystal has settled.
      if (state_q == ST_POWER_DOWN && (state_d == ST_RECEIVE || state_d == ST_TRANSMIT)) begin
         state_d = ST_STANDBY;
      end else if (state_q == ST_STANDBY && !xtal_ok && (state_d == ST_RECEIVE || state_d == ST_TRANSMIT)) begin
         state_d = ST_STANDBY;
      end
   end

   // ---------------------------------------------------------------
   // Mode outputs and modulator control
   // ---------------------------------------------------------------
   logic osc_d;
   logic rx_d;
   logic tx_d;
   logic pa_d;
   logic mod_en_d;
   logic filt_en_d;
   logic osc_q;
   logic rx_q;
   logic tx_q;
   logic pa_q;
   logic mod_en_q;
   logic filt_en_q;
   logic lock_q;
   fsk_mod_cfg_t cfg_q;

   always_comb begin
      osc_d = (state_d != ST_POWER_DOWN);
      rx_d = (state_d == ST_RECEIVE);
      tx_d = (state_d == ST_TRANSMIT);
      pa_d = tx_d && (pa_level_in != PA_OFF);
      mod_en_d = tx_d && (!vco_mod_sel_in || pin_driven);
      filt_en_d = (mod_cfg_in.mod_filter != FILT_OFF);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         state_q <= ST_POWER_DOWN;
         osc_q <= 1'b0;
         rx_q <= 1'b0;
         tx_q <= 1'b0;
         pa_q <= 1'b0;
         mod_en_q <= 1'b0;
         filt_en_q <= 1'b0;
         lock_q <= 1'b0;
         cfg_q <= '0;
      end else if (ce_in) begin
         state_q <= state_d;
         osc_q <= osc_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         pa_q <= pa_d;
         mod_en_q <= mod_en_d;
         filt_en_q <= filt_en_d;
         lock_q <= lock_sync && (rx_d || tx_d);
         cfg_q <= mod_cfg_in;
      end
   end

   fsk_clk_div u_div (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .ce_in(ce_in),
      .run_in(mod_en_q),
      .ref_divider_in(cfg_q.ref_divider),
      .clk_select_in(cfg_q.modulator_clock_select),
      .tick_out(mod_clk_tick_out)
   );

   // ---------------------------------------------------------------
   // Line coder
   // ---------------------------------------------------------------
   logic [3:0] sh_q;
   logic [3:0] sh_d;
   logic [2:0] left_q;
   logic [2:0] left_d;
   logic [2:0] grp_q;
   logic [2:0] grp_d;
   logic [1:0] gcnt_q;
   logic [1:0] gcnt_d;
   logic flag_a_q;
   logic flag_a_d;
   logic out_q;
   logic out_d;
   logic ov_q;
   logic ov_d;
   logic rdy_d;
   logic rdy_q;
   logic [2:0] g;

   always_comb begin
      sh_d = sh_q;
      left_d = left_q;
      grp_d = grp_q;
      gcnt_d = gcnt_q;
      flag_a_d = flag_a_q;
      out_d = out_q;
      ov_d = 1'b0;
      g = {grp_q[1:0], msg_bit_in};
      if (msg_start_in) begin
         flag_a_d = 1'b0;
         gcnt_d = 2'h0;
         left_d = CNT_ZERO;
      end else if (left_q != CNT_ZERO) begin
         out_d = sh_q[3];
         ov_d = 1'b1;
         sh_d = {sh_q[2:0], 1'b0};
         left_d = left_q - CNT_ONE;
      end else if (msg_bit_valid_in) begin
         unique case (code_sel_in)
            CODE_MANCH: begin
               sh_d = {(msg_bit_in ? MANCH_ONE : MANCH_ZERO), 2'h0};
               left_d = LEN_MANCH;
            end
            CODE_THREE_TO_FOUR_BIT_CODE: begin
               if (gcnt_q == GRP_LAST) begin
                  gcnt_d = 2'h0;
                  left_d = LEN_WORD;
                  unique case (g)
                     3'h0: sh_d = flag_a_q ? W000_B : W000_A;
                     3'h1: sh_d = W001;
                     3'h2: sh_d = W010;
                     3'h3: sh_d = W011;
                     3'h4: sh_d = W100;
                     3'h5: sh_d = W101;
                     3'h6: sh_d = W110;
                     3'h7: sh_d = flag_a_q ? W111_B : W111_A;
                  endcase
                  if (g == 3'h0 || g == 3'h7) begin
                     flag_a_d = !flag_a_q;
                  end
               end else begin
                  grp_d = g;
                  gcnt_d = gcnt_q + 2'h1;
               end
            end
            default: begin
               sh_d = {msg_bit_in, 3'h0};
               left_d = LEN_PASS;
            end
         endcase
      end
      rdy_d = !msg_start_in && (left_d == CNT_ZERO);
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sh_q <= 4'h0;
         left_q <= CNT_ZERO;
         grp_q <= 3'h0;
         gcnt_q <= 2'h0;
         flag_a_q <= 1'b0;
         out_q <= 1'b0;
         ov_q <= 1'b0;
         rdy_q <= 1'b0;
      end else if (ce_in) begin
         sh_q <= sh_d;
         left_q <= left_d;
         grp_q <= grp_d;
         gcnt_q <= gcnt_d;
         flag_a_q <= flag_a_d;
         out_q <= out_d;
         ov_q <= ov_d;
         rdy_q <= rdy_d;
      end
   end

   assign msg_bit_ready_out = rdy_q;
   assign line_bit_out = out_q;
   assign line_bit_valid_out = ov_q;
   assign state_out = state_q;
   assign osc_on_out = osc_q;
   assign rx_on_out = rx_q;
   assign tx_on_out = tx_q;
   assign pa_on_out = pa_q;
   assign modulator_en_out = mod_en_q;
   assign mod_current_out = cfg_q.mod_current;
   assign mod_atten_out = cfg_q.mod_atten;
   assign mod_filter_out = cfg_q.mod_filter;
   assign filter_en_out = filt_en_q;
   assign lock_out = lock_q;
endmodule : fsk_seq
`default_nettype wire

// *** test/fsk_seq_asserts.sv ***
// Checker for the FSK mode sequencer at its ports.
`timescale 1ns/1ns
`default_nettype none
module fsk_seq_asserts
   import fsk_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic ce_in,
   input wire logic [1:0] main_mode_in,
   input wire fsk_mod_cfg_t mod_cfg_in,
   input wire logic vco_mod_sel_in,
   input wire logic tx_data_pin_driven_in,
   input wire logic [3:0] state_out,
   input wire logic modulator_en_out,
   input wire logic mod_clk_tick_out,
   input wire logic [MODCUR_W-1:0] mod_current_out,
   input wire logic [ATTEN_W-1:0] mod_atten_out,
   input wire logic [FILT_W-1:0] mod_filter_out,
   input wire logic filter_en_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic [19:0] gap_q, gap_d;
   logic seen_q, seen_d;
   always_comb begin
      gap_d = !ce_in ? gap_q : (mod_clk_tick_out ? 20'h00001 : gap_q + 20'h00001);
      seen_d = modulator_en_out && (seen_q || mod_clk_tick_out);
   end
   always_ff @(posedge core_clk_in) begin
      gap_q <= rst_n_in ? gap_d : 20'h00000;
      seen_q <= rst_n_in && seen_d;
   end
   sequence cfg_settled;
      (ce_in && $stable(mod_cfg_in))[*4];
   endsequence
   sequence pin_floating;
      (ce_in && vco_mod_sel_in && !tx_data_pin_driven_in)[*4];
   endsequence
   tick_gap_a: assert property (
      ce_in && mod_clk_tick_out && seen_q |->
      gap_q == ({14'h0000, mod_cfg_in.ref_divider} << (3'h7 - mod_cfg_in.modulator_clock_select)))
      else $error("modulator tick spacing wrong");
   cfg_copy_a: assert property (cfg_settled |-> mod_current_out == mod_cfg_in.mod_current &&
      mod_atten_out == mod_cfg_in.mod_atten && mod_filter_out == mod_cfg_in.mod_filter)
      else $error("modulator setting copy wrong");
   filter_en_a: assert property (cfg_settled |-> filter_en_out == (mod_cfg_in.mod_filter != FILT_OFF))
      else $error("filter enable wrong");
   pd_enter_a: assert property (ce_in && main_mode_in == MODE_POWER_DOWN |=> state_out == 4'h1)
      else $error("power down not entered");
   pd_hop_a: assert property (ce_in && state_out == 4'h1 |=> state_out inside {4'h1, 4'h2})
      else $error("left power down without standby");
   mod_hold_a: assert property (pin_floating |-> !modulator_en_out)
      else $error("modulator on while pin floats");
endmodule : fsk_seq_asserts
bind fsk_seq fsk_seq_asserts u_fsk_seq_asserts (.core_clk_in, .rst_n_in, .ce_in, .main_mode_in, .mod_cfg_in,
   .vco_mod_sel_in, .tx_data_pin_driven_in, .state_out, .modulator_en_out, .mod_clk_tick_out, .mod_current_out,
   .mod_atten_out, .mod_filter_out, .filter_en_out);
`default_nettype wire

// *** test/fsk_host_model.sv ***
// Host model that steps the device through its modes.
`timescale 1ns/1ns
`default_nettype none
module fsk_host_model
   import fsk_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic [1:0] want_in,
   input wire logic skip_in,
   input wire logic lock_in,
   output logic [1:0] mode_out,
   output logic [2:0] pa_out,
   output logic drive_out
);
   localparam int SETTLE = 8;
   initial begin
      mode_out = MODE_POWER_DOWN;
      pa_out = 3'h0;
      drive_out = 1'b0;
      forever begin
         @(posedge core_clk_in);
         #1;
         if (rst_n_in && want_in != mode_out) begin
            drive_out = 1'b0;
            pa_out = 3'h0;
            if (mode_out == MODE_POWER_DOWN && want_in[1] && !skip_in) begin
               mode_out = MODE_STANDBY;
               repeat (SETTLE) @(posedge core_clk_in);
               #1;
            end
            mode_out = want_in;
            if (want_in == MODE_TRANSMIT) begin
               @(posedge core_clk_in);
               #1;
               pa_out = 3'h7;
               while (lock_in !== 1'b1 && want_in == MODE_TRANSMIT) @(posedge core_clk_in);
               #1;
               drive_out = lock_in && want_in == MODE_TRANSMIT;
            end
         end
      end
   end
endmodule : fsk_host_model
`default_nettype wire

// *** test/tb_top.sv ***
// Testbench for the FSK mode sequencer and line coder.
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import fsk_pkg::*;
;
   logic core_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic ce = 1'b1;
   logic xtal = 1'b0, lock = 1'b0, skip = 1'b0, start = 1'b0, valid = 1'b0, bit_v = 1'b0;
   logic [1:0] want = MODE_POWER_DOWN, code = CODE_NONE, mode;
   logic [2:0] pa, filt;
   logic [3:0] state, att;
   logic [4:0] cur;
   logic drive, ready, line, line_v, osc, rxo, txo, pao, mod_en, tick, filt_en, lock_o;
   fsk_mod_cfg_t cfg = '{6'h03, 3'h6, 5'h11, 4'h9, 3'h0};
   int num_errors = 0, tests_run = 0, cyc = 0;
   logic q[$];
   fsk_host_model u_fsk_host_model (.core_clk_in, .rst_n_in, .want_in(want), .skip_in(skip), .lock_in(lock_o),
      .mode_out(mode), .pa_out(pa), .drive_out(drive));
   fsk_seq u_fsk_seq (.core_clk_in, .rst_n_in, .ce_in(ce), .main_mode_in(mode), .pa_level_in(pa),
      .xtal_settled_in(xtal), .synth_lock_indication_in(lock), .mod_cfg_in(cfg), .vco_mod_sel_in(1'b1),
      .tx_data_pin_driven_in(drive), .tx_data_pin_level_in(1'b0), .code_sel_in(code), .msg_start_in(start),
      .msg_bit_valid_in(valid), .msg_bit_in(bit_v), .msg_bit_ready_out(ready), .line_bit_out(line),
      .line_bit_valid_out(line_v), .state_out(state), .osc_on_out(osc), .rx_on_out(rxo), .tx_on_out(txo),
      .pa_on_out(pao), .modulator_en_out(mod_en), .mod_clk_tick_out(tick), .mod_current_out(cur),
      .mod_atten_out(att), .mod_filter_out(filt), .filter_en_out(filt_en), .lock_out(lock_o));
   initial forever #4 core_clk_in = ~core_clk_in;
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge core_clk_in) begin
      cyc++;
      if (line_v === 1'b1) q.push_back(line);
      if (cyc == 20000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick_n(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask : tick_n
   task automatic send(input logic b);
      tick_n(1);
      for (int n = 0; n < 40 && ready !== 1'b1; n++) tick_n(1);
      valid = 1'b1;
      bit_v = b;
      tick_n(1);
      valid = 1'b0;
   endtask : send
   task automatic run_msg(input logic [1:0] c, input logic [26:0] bits, input int n, input logic [35:0] exp);
      logic [35:0] got;
      code = c;
      start = 1'b1;
      tick_n(1);
      start = 1'b0;
      chk("ready after start", ready, 1'b0);
      q.delete();
      for (int i = n - 1; i >= 0; i--) send(bits[i]);
      tick_n(8);
      got = '0;
      foreach (q[i]) got = {got[34:0], q[i]};
      chk("line bits", got, exp);
   endtask : run_msg
   task automatic t_power;
      int a, b;
      skip = 1'b1;
      want = MODE_TRANSMIT;
      tick_n(8);
      chk("held in standby", state, 4'h2);
      xtal = 1'b1;
      tick_n(8);
      chk("transmit after settle", state, 4'h8);
      want = MODE_POWER_DOWN;
      tick_n(8);
      chk("power down", {osc, state}, 5'h01);
      skip = 1'b0;
      want = MODE_TRANSMIT;
      tick_n(30);
      chk("transmit, pin floating", {pao, txo, mod_en, state}, 7'h68);
      lock = 1'b1;
      tick_n(16);
      chk("locked, modulating", {lock_o, mod_en}, 2'h3);
      chk("settings", {cur, att, filt, filt_en}, 13'h1190);
      for (a = 0; a < 300 && tick !== 1'b1; a++) tick_n(1);
      for (b = 1; b < 300; b++) begin
         tick_n(1);
         if (tick === 1'b1) break;
      end
      chk("tick spacing", b, 6);
      cfg.mod_filter = 3'h7;
      tick_n(6);
      chk("filter max", {filt, filt_en}, 4'hF);
      $display("test power and transmit done");
   endtask : t_power
   task automatic t_coding;
      run_msg(CODE_MANCH, 27'h1, 2, 36'h9);
      run_msg(CODE_THREE_TO_FOUR_BIT_CODE, 27'h7EB02E5, 27, 36'hD236BCA59);
      run_msg(CODE_THREE_TO_FOUR_BIT_CODE, 27'h0, 6, 36'hB4);
      run_msg(CODE_NONE, 27'h555555, 24, 36'h555555);
      $display("test line coding done");
   endtask : t_coding
   task automatic t_modes;
      logic [1:0] m[3] = '{MODE_RECEIVE, MODE_STANDBY, MODE_POWER_DOWN};
      logic [5:0] s[3] = '{6'h34, 6'h12, 6'h01};
      foreach (m[i]) begin
         want = m[i];
         tick_n(16);
         chk("mode state", {rxo, osc, state}, s[i]);
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_hold;
      ce = 1'b0;
      want = MODE_STANDBY;
      tick_n(8);
      chk("frozen by enable", state, 4'h1);
      ce = 1'b1;
      tick_n(4);
      chk("standby after enable", {osc, state}, 5'h12);
      $display("test clock enable done");
   endtask : t_hold
   initial begin
      repeat (16) @(posedge core_clk_in);
      #1;
      rst_n_in = 1'b1;
      t_power();
      t_coding();
      t_modes();
      t_hold();
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
